/* File: logic/asc_pkg.sv */
package asc_pkg;
   // special function register addresses
   localparam logic [7:0] ADDR_CLOCK_PRESCALER = 8'h95;
   localparam logic [7:0] ADDR_RESULT = 8'h96;
   localparam logic [7:0] ADDR_CONTROL = 8'h97;
   // reset values
   localparam logic [7:0] RST_PRESCALER = 8'h00;
   localparam logic [7:0] RST_RESULT = 8'h00;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   // control register field positions
   localparam int CTL_ENABLE_BIT = 5;
   localparam int CTL_SEL_HI_BIT = 3;
   localparam int CTL_SEL_LO_BIT = 2;
   localparam int CTL_START_BIT = 1;
   localparam int CTL_DONE_BIT = 0;
   // conversion timing in converter clocks
   localparam int CLOCKS_PER_BIT = 8;
   localparam int RESULT_BITS = 8;
   localparam int CONV_CLOCKS = CLOCKS_PER_BIT * RESULT_BITS;
   // fixed halving of the mcu clock ahead of the prescaler
   localparam int PRE_HALF = 2;
   // conversion states
   typedef enum logic [1:0] {ASC_IDLE, ASC_CONV, ASC_DONE} asc_state_e;
endpackage

/* File: logic/asc_tick_gen.sv */
`timescale 1ns/1ps
// converter clock tick: one pulse per 2*(divider+1) mcu clocks
module asc_tick_gen
(
   input wire logic clk, // mcu clock
   input wire logic reset, // synchronous, active high
   input wire logic run, // counting allowed
   input wire logic [7:0] divider, // prescaler value
   output logic tick // one-cycle converter clock pulse
);
   logic [8:0] count_q;
   logic [8:0] count_d;
   logic [8:0] limit;
   logic at_limit;

   // terminal count is 2*(n+1)-1, so 9 bits hold the widest case
   assign limit = {divider, 1'b1};
   assign at_limit = (count_q == limit);
   assign count_d = (!run || at_limit) ? 9'h000 : count_q + 9'h001;
   assign tick = run && at_limit;

   // free count restarts on each conversion so ticks align to start
   always_ff @(posedge clk)
   begin
      if (reset)
         count_q <= 9'h000;
      else
         count_q <= count_d;
   end
endmodule

/* File: logic/asc_adc_ctrl.sv */
`timescale 1ns/1ps
module asc_adc_ctrl
#(
   parameter int BITS = asc_pkg::RESULT_BITS, // result width
   parameter int CLK_PER_BIT = asc_pkg::CLOCKS_PER_BIT // clocks per bit
)
(
   input wire logic clk, // mcu clock, 40 MHz
   input wire logic reset, // synchronous, active high
   input wire logic [7:0] sfr_addr, // special function register address
   input wire logic [7:0] sfr_wdata, // write data
   input wire logic sfr_wr, // write strobe, one cycle
   input wire logic sfr_rd, // read strobe, one cycle
   output logic [7:0] sfr_rdata, // read data, registered
   input wire logic done_interrupt_enable, // from power control reg
   input wire logic external_interrupt_one_pin, // pin level
   output logic external_interrupt_one, // interrupt line to core
   input wire logic comparator_high, // ladder at or below sampled input
   output logic [1:0] analog_mux_select, // sample-and-hold input choice
   output logic converter_power, // analog part powered
   output logic sample_hold, // sample-and-hold in hold
   output logic [BITS-1:0] ladder_code // trial code to the ladder
);
   // the counters below are sized for eight bits of result
   if (BITS != 8 || CLK_PER_BIT < 1 || CLK_PER_BIT > 16)
   begin
      $error("asc_adc_ctrl: unsupported BITS or CLK_PER_BIT");
   end

   asc_pkg::asc_state_e state_q, state_d;
   logic [7:0] converter_clock_divider_q;
   logic [7:0] conversion_result_q;
   logic converter_enable_q;
   logic [1:0] channel_q;
   logic conversion_start_q;
   logic conversion_done_q;
   logic [BITS-1:0] trial_q;
   logic [BITS-1:0] bit_mask_q;
   logic [3:0] sub_q;
   logic tick;
   logic [7:0] rdata_q;

   // address decode
   logic wr_pre, wr_ctl, start_req, go, bit_end, last_bit;
   logic wr_off, tick_run;
   assign wr_pre = sfr_wr && (sfr_addr == asc_pkg::ADDR_CLOCK_PRESCALER);
   assign wr_ctl = sfr_wr && (sfr_addr == asc_pkg::ADDR_CONTROL);
   assign start_req = wr_ctl && sfr_wdata[asc_pkg::CTL_START_BIT];
   assign go = start_req && sfr_wdata[asc_pkg::CTL_ENABLE_BIT];
   // a control write that clears enable shuts the converter off at once
   assign wr_off = wr_ctl && !sfr_wdata[asc_pkg::CTL_ENABLE_BIT];
   // a restart realigns the tick phase, so no short first bit
   assign tick_run = (state_q == asc_pkg::ASC_CONV) && !go;
   assign bit_end = tick && (sub_q == 4'(CLK_PER_BIT - 1));
   assign last_bit = bit_mask_q[0];

   asc_tick_gen u_tick
   (
      .clk(clk),
      .reset(reset),
      .run(tick_run),
      .divider(converter_clock_divider_q),
      .tick(tick)
   );

   // state sequencing
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         asc_pkg::ASC_IDLE:
         begin
            if (go)
               state_d = asc_pkg::ASC_CONV;
         end
         asc_pkg::ASC_CONV:
         begin
            // a converter switched off mid-way abandons the conversion
            if (!converter_enable_q || wr_off)
               state_d = asc_pkg::ASC_IDLE;
            else if (bit_end && last_bit)
               state_d = asc_pkg::ASC_DONE;
         end
         asc_pkg::ASC_DONE:
         begin
            state_d = go ? asc_pkg::ASC_CONV : asc_pkg::ASC_IDLE;
         end
         default:
            state_d = asc_pkg::ASC_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         state_q <= asc_pkg::ASC_IDLE;
      else
         state_q <= state_d;
   end

   // prescaler and control fields
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         converter_clock_divider_q <= asc_pkg::RST_PRESCALER;
         converter_enable_q <= asc_pkg::RST_CONTROL[asc_pkg::CTL_ENABLE_BIT];
         channel_q <= asc_pkg::RST_CONTROL[3:2];
      end
      else
      begin
         if (wr_pre)
            converter_clock_divider_q <= sfr_wdata;
         if (wr_ctl)
            converter_enable_q <= sfr_wdata[asc_pkg::CTL_ENABLE_BIT];
         if (wr_ctl)
            channel_q <= {sfr_wdata[asc_pkg::CTL_SEL_HI_BIT],
                          sfr_wdata[asc_pkg::CTL_SEL_LO_BIT]};
      end
   end

   // start bit self-clears after one cycle
   always_ff @(posedge clk)
   begin
      if (reset)
         conversion_start_q <= asc_pkg::RST_CONTROL[asc_pkg::CTL_START_BIT];
      else
         conversion_start_q <= go;
   end

   // done flag: software cannot write it, only a start clears it
   always_ff @(posedge clk)
   begin
      if (reset)
         conversion_done_q <= asc_pkg::RST_CONTROL[asc_pkg::CTL_DONE_BIT];
      else if (go || state_q == asc_pkg::ASC_CONV)
         conversion_done_q <= 1'b0;
      else if (state_q == asc_pkg::ASC_DONE)
         conversion_done_q <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         trial_q <= '0;
         bit_mask_q <= '0;
         sub_q <= 4'h0;
      end
      else if (go)
      begin
         trial_q <= {1'b1, {(BITS-1){1'b0}}};
         bit_mask_q <= {1'b1, {(BITS-1){1'b0}}};
         sub_q <= 4'h0;
      end
      else if (tick)
      begin
         sub_q <= bit_end ? 4'h0 : sub_q + 4'h1;
         if (bit_end)
         begin
            // keep or drop the bit under test, then try the next one
            trial_q <= (trial_q & ~(bit_mask_q & {BITS{!comparator_high}}))
                       | (bit_mask_q >> 1);
            bit_mask_q <= bit_mask_q >> 1;
         end
      end
   end

   // unsigned code loaded only at the end
   always_ff @(posedge clk)
   begin
      if (reset)
         conversion_result_q <= asc_pkg::RST_RESULT;
      else if (state_q == asc_pkg::ASC_DONE)
         conversion_result_q <= trial_q;
   end

   // register read-back; reserved bits read zero
   logic [7:0] ctl_view, rd_mux;
   assign ctl_view = {2'b00, converter_enable_q, 1'b0, channel_q,
                      conversion_start_q, conversion_done_q};
   assign rd_mux = (sfr_addr == asc_pkg::ADDR_CLOCK_PRESCALER)
                   ? converter_clock_divider_q
                 : (sfr_addr == asc_pkg::ADDR_RESULT) ? conversion_result_q
                 : (sfr_addr == asc_pkg::ADDR_CONTROL) ? ctl_view : 8'h00;

   always_ff @(posedge clk)
   begin
      if (reset)
         rdata_q <= 8'h00;
      else if (sfr_rd)
         rdata_q <= rd_mux;
   end

   // done bit low while busy holds the line high; setting it at completion gives a falling edge
   // interrupt source swaps from pin to converter
   assign external_interrupt_one = done_interrupt_enable
                                   ? !conversion_done_q
                                   : external_interrupt_one_pin;

   assign sfr_rdata = rdata_q;
   assign analog_mux_select = channel_q;
   assign converter_power = converter_enable_q;
   assign sample_hold = (state_q == asc_pkg::ASC_CONV);
   assign ladder_code = trial_q;
endmodule

/* File: bench/asc_ctl_properties.sv */
`timescale 1ns/1ps
module asc_ctl_chk
#(parameter int BITS = 8, parameter int CLK_PER_BIT = 8)
(
   input wire logic clk, // clock
   input wire logic reset, // reset
   input wire logic [7:0] sfr_addr, // addr
   input wire logic [7:0] sfr_wdata, // data
   input wire logic sfr_wr, // write
   input wire logic done_interrupt_enable, // irq on
   input wire logic external_interrupt_one_pin, // pin
   input wire logic external_interrupt_one, // irq
   input wire logic [1:0] analog_mux_select, // mux
   input wire logic converter_power, // power
   input wire logic sample_hold, // hold
   input wire logic [BITS-1:0] ladder_code // trial
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // control write; a start only counts with power on
   wire ctl_wr = sfr_wr && sfr_addr == 8'h97;
   sequence s_go; ctl_wr && sfr_wdata[5] && sfr_wdata[1]; endsequence
   a_power_follow: assert property (ctl_wr |=>
      converter_power == $past(sfr_wdata[5])) else $error("power");
   a_mux_follow: assert property (ctl_wr |=>
      analog_mux_select == $past(sfr_wdata[3:2])) else $error("mux");
   a_pin_pass: assert property (!done_interrupt_enable |->
      external_interrupt_one == external_interrupt_one_pin) else $error("pin");
   a_start_trial: assert property (s_go |=> sample_hold
      && ladder_code == 8'h80) else $error("start");
   a_start_ignore: assert property (ctl_wr && !sfr_wdata[5] |=>
      !sample_hold) else $error("ignore");
   a_busy_high: assert property (done_interrupt_enable &&
      sample_hold |-> external_interrupt_one) else $error("busy");
   a_done_fall: assert property ($fell(sample_hold) &&
      converter_power && done_interrupt_enable |->
      ##[0:3] !external_interrupt_one) else $error("done");
   a_bit_pace: assert property ($changed(ladder_code) && sample_hold
      |=> (!sample_hold || $stable(ladder_code))[*7]) else $error("pace");
endmodule
bind asc_adc_ctrl asc_ctl_chk #(.BITS(BITS), .CLK_PER_BIT(CLK_PER_BIT))
   chk_u
   (
      .clk(clk),
      .reset(reset),
      .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr),
      .done_interrupt_enable(done_interrupt_enable),
      .external_interrupt_one_pin(external_interrupt_one_pin),
      .external_interrupt_one(external_interrupt_one),
      .analog_mux_select(analog_mux_select),
      .converter_power(converter_power),
      .sample_hold(sample_hold),
      .ladder_code(ladder_code)
   );

/* File: bench/asc_analog_model.sv */
`timescale 1ns/1ps
// analog side: input mux and comparator
module asc_analog_model
#(parameter logic [31:0] LEVELS = 32'h5aa5_00ff)
(
   input wire logic clk, // clock
   input wire logic [1:0] analog_mux_select, // mux
   input wire logic converter_power, // power
   input wire logic sample_hold, // hold
   input wire logic [7:0] ladder_code, // trial
   output logic comparator_high // keep bit
);
   logic junk_q = 1'b0;
   // idle comparator toggles, so a stale level cannot pass
   always_ff @(posedge clk)
      junk_q <= ~junk_q;
   // pins taken as already in analog function
   // selected input against the trial code
   assign comparator_high = converter_power && sample_hold ?
      LEVELS[analog_mux_select * 8 +: 8] >= ladder_code : junk_q;
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0, reset = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
   logic done_interrupt_enable = 1'b0;
   logic external_interrupt_one_pin = 1'b1;
   logic external_interrupt_one, comparator_high;
   logic converter_power, sample_hold;
   logic [1:0] analog_mux_select;
   logic [7:0] ladder_code;
   logic [7:0] lv [4] = '{8'hff, 8'h00, 8'ha5, 8'h5a};
   logic [7:0] last_res = 8'h00;
   int n_errors = 0, check_count = 0;
   // 40 MHz clock
   always #12.5 clk = ~clk;
   asc_adc_ctrl dut_u
   (
      .clk(clk),
      .reset(reset),
      .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata),
      .done_interrupt_enable(done_interrupt_enable),
      .external_interrupt_one_pin(external_interrupt_one_pin),
      .external_interrupt_one(external_interrupt_one),
      .comparator_high(comparator_high),
      .analog_mux_select(analog_mux_select),
      .converter_power(converter_power),
      .sample_hold(sample_hold),
      .ladder_code(ladder_code)
   );
   asc_analog_model ana_u
   (
      .clk(clk),
      .analog_mux_select(analog_mux_select),
      .converter_power(converter_power),
      .sample_hold(sample_hold),
      .ladder_code(ladder_code),
      .comparator_high(comparator_high)
   );
   task automatic chk(input string s, input logic [7:0] v, e);
      check_count++;
      n_errors += int'(v !== e);
      if (v !== e)
         $display("Error %s expected %h seen %h", s, e, v);
   endtask
   // one strobe cycle, moved only at falling edges
   task automatic bus(input logic [7:0] a, d, input logic w);
      @(negedge clk);
      {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {a, d, w, !w};
      @(negedge clk);
      {sfr_wr, sfr_rd} = 2'h0;
   endtask
   task automatic rd(input logic [7:0] a, e, input string s);
      bus(a, 8'h00, 1'b0);
      chk(s, sfr_rdata, e);
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // channel c at prescaler c; done seen on the interrupt line
   task automatic conv(input logic [1:0] c, input logic [7:0] e);
      int t;
      bus(8'h95, {6'h0, c}, 1'b1);
      bus(8'h97, {4'h2, c, 2'h2}, 1'b1);
      rd(8'h97, {4'h2, c, 2'h0}, "busy");
      rd(8'h96, last_res, "hold");
      for (t = 4; external_interrupt_one !== 1'b0 && t < 600; t++)
         @(negedge clk);
      t = t - 128 * (c + 1);
      chk("time", {7'h0, t >= 0 && t <= 4}, 8'h01);
      if (t > 4)
         end_of_test();
      rd(8'h96, e, "result");
      rd(8'h97, {4'h2, c, 2'h1}, "done");
      last_res = e;
   endtask
   // reset, register map, conversions, refused accesses
   initial
   begin
      repeat (16) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      external_interrupt_one_pin = 1'b0;
      for (int a = 8'h95; a < 8'h99; a++)
         rd(8'(a), 8'h00, "reset");
      chk("pin", {7'h0, external_interrupt_one}, 8'h00);
      done_interrupt_enable = 1'b1;
      @(negedge clk);
      chk("swap", {7'h0, external_interrupt_one}, 8'h01);
      for (int i = 0; i < 4; i++)
         conv(2'(i), lv[i]);
      bus(8'h97, 8'h02, 1'b1);
      rd(8'h97, 8'h01, "off");
      bus(8'h96, 8'h3c, 1'b1);
      rd(8'h96, 8'h5a, "ro");
      end_of_test();
   end
endmodule
